// ---- core/rbd_defines.svh ----
// Register offsets, reset values, masks and timing constants
`ifndef RBD_DEFINES_SVH
`define RBD_DEFINES_SVH

`define RBD_OFS_CTRL 12'h000
`define RBD_OFS_FREQ 12'h004
`define RBD_OFS_TIME 12'h008
`define RBD_OFS_BRK 12'h00C
`define RBD_OFS_FLUX 12'h010
`define RBD_OFS_STAT 12'h014

`define RBD_MASK_CTRL 32'h00DF_7FFF
`define RBD_MASK_FREQ 32'h00FF_FFFF
`define RBD_MASK_TIME 32'h03FF_03FF
`define RBD_MASK_BRK 32'h007F_03FF
`define RBD_MASK_FLUX 32'h7F7F_03FF

`define RBD_RST_CTRL 32'h0000_0000
`define RBD_RST_DC_CUR 7'h32
`define RBD_RST_START_T 10'h000
`define RBD_RST_BOOST 10'h000
`define RBD_RST_MOTOR_CUR 7'h64

// Braking timer resolution in ns, and clock period in ns
`define RBD_TICK_NS 10000000
`define RBD_CLK_NS 40
// Fast flash half period minus one, in 0.01 s ticks
`define RBD_FLASH_TICKS 8'h0A

`define RBD_PCT_FULL 17'h00064
`define RBD_CARRIER_PCT 7'h32
`define RBD_BOOST_CLAMP 7'h50
`define RBD_FREQ_SRCS 5
`define RBD_RUN_SRCS 4

`endif

// ---- core/rbd_pkg.sv ----
// Types shared by the run gating and braking sequencer
package rbd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_START = 3'h1,
        ST_RUN   = 3'h3,
        ST_SHORT = 3'h2,
        ST_STOP  = 3'h6
    } rbd_state_t;

    typedef struct packed {
        logic [7:0] rsvd1;
        logic [1:0] runCmdSrc1;
        logic rsvd2;
        logic [2:0] freqRefSrc1;
        logic [1:0] secondRunCmdSource;
        logic rsvd0;
        logic [2:0] secondFreqRefSource;
        logic extRef2Sel;
        logic [1:0] belowMinFreqAction;
        logic [2:0] controlModeSelect;
        logic [1:0] stopMethodSelect;
        logic powerupRunAccept;
        logic outputPhaseOrderSelect;
        logic [1:0] programModeRunSelect;
    } rbd_ctrl_t;

    typedef struct packed {
        logic dcInject;
        logic shortBrake;
        logic zeroHold;
        logic [11:0] current;
    } rbd_brake_t;

endpackage

// ---- core/rbd_sequencer.sv ----
// Run gating, start/stop braking sequencer and AHB-Lite register slave
//
// How it works
// (RULE1) Selection 0: no run accepted while keypad is in programming menus.
// (RULE2) Selection 1: run accepted in every keypad mode.
// (RULE3) Selection 2: programming entry and display refused while output active.
// (RULE4) Phase order 0 standard, 1 swaps two phases to reverse motor.
// (RULE5) Acceptance 0: run present at power-up ignored until it is cycled.
// (RULE6) Run present at power-up while blocked flashes run indicator fast.
// (RULE7) Acceptance 1: active run starts motor once start-up has finished.
// (RULE8) Brake start frequency used only with ramp to stop, 0.0-10.0 Hz.
// (RULE9) Modes 0-2: DC injection below start frequency for stop time.
// (RULE10) Start frequency below minimum: braking begins at minimum frequency.
// (RULE11) Modes 5,6: short-circuit brake, then DC injection if stop time set.
// (RULE12) Modes 3,7: zero speed hold for stop time if below-min action 0.
// (RULE13) Modes 3,7: hold begins at minimum frequency if start freq lower.
// (RULE14) DC current 0-100%, default 50%; above 50% carrier drops to 1 kHz.
// (RULE15) Start braking (hold in modes 3,7) for start time; zero disables.
// (RULE16) Stop braking (hold in modes 3,7) for stop time; zero disables.
// (RULE17) On run, DC current ramps from boost level to no-load over start time.
// (RULE18) Boost current clamped to lesser of 80% drive and motor rated.
// (RULE19) Boost level 0% uses DC braking current instead of the ramp.
// (RULE20) External reference 2 takes second reference and run sources.
// (RULE21) Braking timed in 0.01 s ticks, cleared when a braking phase begins.
`timescale 1ns/1ps
`include "rbd_defines.svh"

module rbd_sequencer #(
    parameter int TICK_CYCLES = `RBD_TICK_NS / `RBD_CLK_NS,
    parameter logic [7:0] BRAKE_FREQ_RST = 8'h05,
    parameter logic [15:0] MIN_FREQ_RST = 16'h000F,
    parameter logic [9:0] STOP_TIME_RST = 10'h032,
    parameter logic [9:0] SHORT_TIME_RST = 10'h000,
    parameter logic [6:0] NO_LOAD_RST = 7'h1E
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [`RBD_RUN_SRCS-1:0] runCmdIn,
    input wire logic [15:0] freqRefIn [`RBD_FREQ_SRCS],
    input wire logic [15:0] outputFreq,
    input wire logic keypadProgMode,
    input wire logic progEntryReq,
    input wire logic startupDone,
    input wire logic [2:0] phaseGate,
    output logic [2:0] phaseOut,
    output logic [15:0] freqRefOut,
    output logic progEntryGrant,
    output logic progDisplayEn,
    output logic runLed,
    output logic driveActive,
    output logic carrierLow,
    output rbd_pkg::rbd_brake_t brakeOut
);
    import rbd_pkg::*;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    localparam int TW = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

    rbd_ctrl_t ctrl_q;
    logic [7:0] brakeFreq_q;
    logic [15:0] minFreq_q;
    logic [9:0] startTime_q, stopTime_q, shortTime_q;
    logic [6:0] dcCur_q, noLoad_q, motorCur_q;
    logic [9:0] boost_q;
    logic wrEn_q;
    logic [11:0] wrAddr_q;
    logic [31:0] hrdata_q;
    rbd_state_t state_q, state_d;
    logic [TW-1:0] tickCnt_q;
    logic [10:0] brkCnt_q;
    logic started_q, pwrBlock_q, ledFlash_q;
    logic runOk;
    logic [7:0] flashCnt_q;
    logic [2:0] phaseOut_q;
    logic [15:0] freqRefOut_q;
    logic carrierLow_q;
    rbd_brake_t brake_q, brake_d;

    // Bus decode; every transfer is zero wait state with an OKAY answer
    wire addrPhase = hsel && hready && htrans[1];
    wire [11:0] regAddr = haddr[11:0];
    wire mapped = (haddr[31:12] == 20'h00000);
    wire selCtrl = mapped && regAddr == `RBD_OFS_CTRL;
    wire selFreq = mapped && regAddr == `RBD_OFS_FREQ;
    wire selTime = mapped && regAddr == `RBD_OFS_TIME;
    wire selBrk = mapped && regAddr == `RBD_OFS_BRK;
    wire selFlux = mapped && regAddr == `RBD_OFS_FLUX;
    wire selStat = mapped && regAddr == `RBD_OFS_STAT;
    wire wrCtrl = wrEn_q && wrAddr_q == `RBD_OFS_CTRL;
    wire wrFreq = wrEn_q && wrAddr_q == `RBD_OFS_FREQ;
    wire wrTime = wrEn_q && wrAddr_q == `RBD_OFS_TIME;
    wire wrBrk = wrEn_q && wrAddr_q == `RBD_OFS_BRK;
    wire wrFlux = wrEn_q && wrAddr_q == `RBD_OFS_FLUX;
    wire [31:0] wCtrl = hwdata & `RBD_MASK_CTRL;
    wire [31:0] wFreq = hwdata & `RBD_MASK_FREQ;
    wire [31:0] wTime = hwdata & `RBD_MASK_TIME;
    wire [31:0] wBrk = hwdata & `RBD_MASK_BRK;
    wire [31:0] wFlux = hwdata & `RBD_MASK_FLUX;

    wire [31:0] statWord = {4'h0, brake_q.current, 8'h00, runOk,
        carrierLow_q, progEntryGrant, pwrBlock_q, driveActive, state_q};
    wire [31:0] rdWord =
        selCtrl ? 32'(ctrl_q) :
        selFreq ? {8'h00, minFreq_q, brakeFreq_q} :
        selTime ? {6'h00, stopTime_q, 6'h00, startTime_q} :
        selBrk ? {9'h000, dcCur_q, 6'h00, shortTime_q} :
        selFlux ? {1'b0, motorCur_q, 1'b0, noLoad_q, 6'h00, boost_q} :
        selStat ? statWord : 32'h0000_0000;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wrEn_q <= 1'b0;
            wrAddr_q <= 12'h000;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wrEn_q <= addrPhase && hwrite;
            wrAddr_q <= mapped ? regAddr : 12'hFFF;
            if (addrPhase && !hwrite) begin
                hrdata_q <= rdWord;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= rbd_ctrl_t'(`RBD_RST_CTRL);
            brakeFreq_q <= BRAKE_FREQ_RST;
            minFreq_q <= MIN_FREQ_RST;
            startTime_q <= `RBD_RST_START_T;
            stopTime_q <= STOP_TIME_RST;
            shortTime_q <= SHORT_TIME_RST;
            dcCur_q <= `RBD_RST_DC_CUR;
            boost_q <= `RBD_RST_BOOST;
            noLoad_q <= NO_LOAD_RST;
            motorCur_q <= `RBD_RST_MOTOR_CUR;
        end else begin
            if (wrCtrl) ctrl_q <= rbd_ctrl_t'(wCtrl);
            if (wrFreq) brakeFreq_q <= wFreq[7:0];
            if (wrFreq) minFreq_q <= wFreq[23:8];
            if (wrTime) startTime_q <= wTime[9:0];
            if (wrTime) stopTime_q <= wTime[25:16];
            if (wrBrk) shortTime_q <= wBrk[9:0];
            if (wrBrk) dcCur_q <= wBrk[22:16];
            if (wrFlux) boost_q <= wFlux[9:0];
            if (wrFlux) noLoad_q <= wFlux[22:16];
            if (wrFlux) motorCur_q <= wFlux[30:24];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // (RULE20) source select by reference set
    wire [1:0] runIdx = ctrl_q.extRef2Sel ?
        ctrl_q.secondRunCmdSource : ctrl_q.runCmdSrc1;
    wire [2:0] refIdx = ctrl_q.extRef2Sel ?
        ctrl_q.secondFreqRefSource : ctrl_q.freqRefSrc1;
    wire runSel = runCmdIn[runIdx];
    wire refOk = refIdx < 3'(`RBD_FREQ_SRCS);
    wire [15:0] refSel = refOk ? freqRefIn[refIdx] : 16'h0000;

    // (RULE1) programming blocks run
    wire progBlock = ctrl_q.programModeRunSelect == 2'h0 && keypadProgMode;
    // (RULE2) (RULE7) run accepted after start-up
    assign runOk = started_q && runSel && !pwrBlock_q && !progBlock;
    // (RULE3) no programming while output active
    wire progLock = ctrl_q.programModeRunSelect == 2'h2 && driveActive;
    assign progEntryGrant = progEntryReq && !progLock;
    assign progDisplayEn = keypadProgMode && !progLock;

    // (RULE5) catch run level once start-up ends
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            started_q <= 1'b0;
            pwrBlock_q <= 1'b0;
        end else if (startupDone && !started_q) begin
            started_q <= 1'b1;
            pwrBlock_q <= !ctrl_q.powerupRunAccept && runSel;
        end else if (!runSel) begin
            pwrBlock_q <= 1'b0;
        end
    end

    // (RULE10) (RULE13) threshold is the higher of the two
    wire [15:0] brakeFreqW = {8'h00, brakeFreq_q};
    wire useMin = brakeFreqW < minFreq_q;
    wire belowStart = useMin ? outputFreq <= minFreq_q
                             : outputFreq < brakeFreqW;
    wire [2:0] mode = ctrl_q.controlModeSelect;
    wire zsMode = mode == 3'h3 || mode == 3'h7;
    wire scMode = mode == 3'h5 || mode == 3'h6;
    // (RULE8) only ramp to stop uses the threshold
    wire rampStop = ctrl_q.stopMethodSelect == 2'h0;
    // (RULE12) hold needs below-min action 0
    wire stopOn = stopTime_q != 10'h000 &&
        (!zsMode || ctrl_q.belowMinFreqAction == 2'h0);

    // (RULE21) 0.01 s tick, restarted with each braking phase
    wire phaseStart = state_d != state_q;
    wire tick = tickCnt_q == TICK_LAST;
    wire [10:0] phaseLen = state_q == ST_START ? {1'b0, startTime_q} :
                           state_q == ST_SHORT ? {1'b0, shortTime_q} :
                                                 {1'b0, stopTime_q};
    wire phaseDone = brkCnt_q >= phaseLen;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // (RULE15) start braking only when time nonzero
                if (runOk) begin
                    state_d = startTime_q != 10'h000 ? ST_START : ST_RUN;
                end
            end
            ST_START: begin
                if (!runOk) begin
                    state_d = ST_IDLE;
                end else if (phaseDone) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!runOk && !rampStop) begin
                    state_d = ST_IDLE;
                end else if (!runOk && belowStart) begin
                    // (RULE9) (RULE11) (RULE12) mode picks the brake
                    if (scMode && shortTime_q != 10'h000) begin
                        state_d = ST_SHORT;
                    end else begin
                        state_d = stopOn ? ST_STOP : ST_IDLE;
                    end
                end
            end
            ST_SHORT: begin
                // (RULE11) DC follows when stop time set
                if (phaseDone) begin
                    state_d = stopOn ? ST_STOP : ST_IDLE;
                end
            end
            ST_STOP: begin
                // (RULE16) end after stop time
                if (phaseDone) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            tickCnt_q <= '0;
            brkCnt_q <= 11'h000;
        end else begin
            state_q <= state_d;
            // (RULE21) clear timer on phase entry
            if (phaseStart || tick) begin
                tickCnt_q <= '0;
            end else begin
                tickCnt_q <= tickCnt_q + 1'b1;
            end
            if (phaseStart) begin
                brkCnt_q <= 11'h000;
            end else if (tick && !phaseDone) begin
                brkCnt_q <= brkCnt_q + 11'h001;
            end
        end
    end

    assign driveActive = state_q != ST_IDLE;

    // (RULE17) linear ramp from boost level to no-load level
    wire [16:0] boostProd = 17'(noLoad_q * boost_q);
    wire [11:0] boostCur = 12'(boostProd / `RBD_PCT_FULL);
    wire signed [12:0] rampSpan = $signed({6'h00, noLoad_q})
        - $signed({1'b0, boostCur});
    wire signed [24:0] rampProd = rampSpan * $signed({1'b0, brkCnt_q});
    wire [9:0] rampDiv = startTime_q == 10'h000 ? 10'h001 : startTime_q;
    wire signed [24:0] rampStep = rampProd / $signed({15'h0000, rampDiv});
    wire signed [24:0] rampSum = $signed({13'h0000, boostCur}) + rampStep;
    wire [11:0] rampCur = rampSum < 0 ? 12'h000 : rampSum[11:0];
    // (RULE18) clamp to lesser of 80% and motor rating
    wire [6:0] clampPct = motorCur_q < `RBD_BOOST_CLAMP ?
        motorCur_q : `RBD_BOOST_CLAMP;
    wire [11:0] clampCur = {5'h00, clampPct};
    wire [11:0] boostOut = rampCur > clampCur ? clampCur : rampCur;
    // (RULE19) no boost means plain DC level
    wire [11:0] startCur = boost_q == 10'h000 ?
        {5'h00, dcCur_q} : boostOut;
    wire braking = state_q == ST_START || state_q == ST_STOP;

    always_comb begin
        brake_d = '0;
        // (RULE15) (RULE16) hold replaces DC in modes 3 and 7
        brake_d.dcInject = braking && !zsMode;
        brake_d.zeroHold = braking && zsMode;
        brake_d.shortBrake = state_q == ST_SHORT;
        if (state_q == ST_START && !zsMode) begin
            brake_d.current = startCur;
        end else if (state_q == ST_STOP && !zsMode) begin
            brake_d.current = {5'h00, dcCur_q};
        end
    end

    // (RULE4) swap two phases to reverse rotation
    wire [2:0] phaseSel = ctrl_q.outputPhaseOrderSelect ?
        {phaseGate[1], phaseGate[2], phaseGate[0]} : phaseGate;

    // (RULE6) fast flash while the power-up run is held off
    wire flashWrap = flashCnt_q >= `RBD_FLASH_TICKS;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            brake_q <= '0;
            phaseOut_q <= 3'h0;
            freqRefOut_q <= 16'h0000;
            carrierLow_q <= 1'b0;
            flashCnt_q <= 8'h00;
            ledFlash_q <= 1'b0;
        end else begin
            brake_q <= brake_d;
            phaseOut_q <= driveActive ? phaseSel : 3'h0;
            freqRefOut_q <= refSel;
            // (RULE14) high DC current forces 1 kHz carrier
            carrierLow_q <= dcCur_q > `RBD_CARRIER_PCT;
            if (!pwrBlock_q) begin
                flashCnt_q <= 8'h00;
                ledFlash_q <= 1'b0;
            end else if (tick && flashWrap) begin
                flashCnt_q <= 8'h00;
                ledFlash_q <= !ledFlash_q;
            end else if (tick) begin
                flashCnt_q <= flashCnt_q + 8'h01;
            end
        end
    end

    assign brakeOut = brake_q;
    assign phaseOut = phaseOut_q;
    assign freqRefOut = freqRefOut_q;
    assign carrierLow = carrierLow_q;
    assign runLed = pwrBlock_q ? ledFlash_q : driveActive;

    // Checks; clock and reset come from the defaults at the top
    property p_prog_block; // (RULE1)
        (progBlock && (state_q == ST_IDLE || state_q == ST_START))
            |=> state_q == ST_IDLE;
    endproperty
    a_prog_block: assert property (p_prog_block) // (RULE1)
        else $error("run accepted in programming mode");
    property p_prog_any; // (RULE2)
        (ctrl_q.programModeRunSelect == 2'h1 && started_q && runSel &&
            !pwrBlock_q && state_q == ST_IDLE) |=> driveActive;
    endproperty
    a_prog_any: assert property (p_prog_any) // (RULE2)
        else $error("run refused with selection 1");
    property p_prog_lock; // (RULE3)
        (ctrl_q.programModeRunSelect == 2'h2 && driveActive)
            |-> !progEntryGrant && !progDisplayEn;
    endproperty
    a_prog_lock: assert property (p_prog_lock) // (RULE3)
        else $error("programming allowed while output active");
    property p_phase; // (RULE4)
        (driveActive && ctrl_q.outputPhaseOrderSelect) ##1
            $stable(ctrl_q) |-> phaseOut == {$past(phaseGate[1]),
            $past(phaseGate[2]), $past(phaseGate[0])};
    endproperty
    a_phase: assert property (p_phase) // (RULE4)
        else $error("phase order not swapped");
    property p_pwr_block; // (RULE5)
        (startupDone && !started_q && !ctrl_q.powerupRunAccept && runSel)
            |=> pwrBlock_q && !runOk;
    endproperty
    a_pwr_block: assert property (p_pwr_block) // (RULE5)
        else $error("power-up run not held off");
    property p_flash; // (RULE6)
        pwrBlock_q |-> runLed == ledFlash_q && !driveActive;
    endproperty
    a_flash: assert property (p_flash) // (RULE6)
        else $error("run indicator not flashing");
    sequence s_short_end;
        state_q == ST_SHORT && phaseDone && stopOn;
    endsequence
    property p_short_dc; // (RULE11)
        s_short_end |=> state_q == ST_STOP && brkCnt_q == 11'h000
            ##1 brakeOut.dcInject;
    endproperty
    a_short_dc: assert property (p_short_dc) // (RULE11)
        else $error("DC injection did not follow short brake");
    property p_hold; // (RULE12)
        (state_q == ST_STOP && zsMode) ##1 $stable(ctrl_q)
            |-> brakeOut.zeroHold && !brakeOut.dcInject;
    endproperty
    a_hold: assert property (p_hold) // (RULE12)
        else $error("zero speed hold missing");
    property p_carrier; // (RULE14)
        $stable(dcCur_q) [*2] |-> carrierLow == (dcCur_q > `RBD_CARRIER_PCT);
    endproperty
    a_carrier: assert property (p_carrier) // (RULE14)
        else $error("carrier request wrong");
    property p_clamp; // (RULE18)
        (state_q == ST_START && boost_q != 10'h000 && !zsMode)
            |=> brakeOut.current <= {5'h00, $past(clampPct)};
    endproperty
    a_clamp: assert property (p_clamp) // (RULE18)
        else $error("boost current above clamp");
    property p_timer; // (RULE21)
        (phaseStart && state_d != ST_IDLE) |=> brkCnt_q == 11'h000 &&
            tickCnt_q == '0;
    endproperty
    a_timer: assert property (p_timer) // (RULE21)
        else $error("brake timer not cleared");

endmodule

// ---- tb/rbd_motor_model.sv ----
// Behavioural motor and modulator feeding frequency and gates
`timescale 1ns/1ps
module rbd_motor_model (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic driveActive,
    input wire logic accel,
    output logic [15:0] outputFreq,
    output logic [2:0] phaseGate
);
    // Gates rotate every cycle so a stuck or swapped phase shows up
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            outputFreq <= 16'h0000;
            phaseGate <= 3'h1;
        end else begin
            phaseGate <= {phaseGate[1:0], phaseGate[2]};
            // Coasts down one step a cycle once the run is removed
            if (driveActive && accel && outputFreq < 16'h012C) begin
                outputFreq <= outputFreq + 16'h0001;
            end else if (!accel && outputFreq != 16'h0000) begin
                outputFreq <= outputFreq - 16'h0001;
            end
        end
    end
endmodule

// ---- tb/rbd_sequencer_tb.sv ----
// Self-checking bench for the run gating and braking sequencer
`timescale 1ns/1ps
module rbd_sequencer_tb;
    import rbd_pkg::*;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic hsel = 1'h0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [15:0] freqRefOut;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [3:0] runCmdIn = 4'h1;
    logic [15:0] freqRefIn [5] = '{5{16'h0000}};
    logic [15:0] outputFreq;
    logic keypadProgMode = 1'h0;
    logic progEntryReq = 1'h0;
    logic startupDone = 1'h1;
    logic [2:0] phaseGate;
    logic [2:0] phaseOut;
    logic progEntryGrant;
    logic progDisplayEn;
    logic runLed;
    logic driveActive;
    logic carrierLow;
    rbd_brake_t brakeOut;
    int error_cnt = 0;
    int n_checks = 0;

    assign hready = hreadyout;
    always #20 mclk = ~mclk;

    rbd_sequencer #(.TICK_CYCLES(10)) dut (.mclk, .rst_b, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
        .hrdata, .runCmdIn, .freqRefIn, .outputFreq, .keypadProgMode,
        .progEntryReq, .startupDone, .phaseGate, .phaseOut, .freqRefOut,
        .progEntryGrant, .progDisplayEn, .runLed, .driveActive, .carrierLow,
        .brakeOut);
    rbd_motor_model mot (.mclk, .rst_b, .driveActive, .accel(runCmdIn[0]),
        .outputFreq, .phaseGate);

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, s);
        n_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic run(input logic v);
        @(posedge mclk);
        runCmdIn[0] <= v;
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge mclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'h1);
        rd = hrdata;
    endtask

    task automatic t_pwrup;
        int tg;
        logic l;
        tg = 0;
        l = runLed;
        repeat (300) begin
            cyc(1);
            chk("held", 1'h0, driveActive);
            tg += int'(runLed !== l);
            l = runLed;
        end
        chk("flash", 1'h1, tg >= 2);
        run(1'h0);
        cyc(4);
        run(1'h1);
        cyc(3);
        chk("cycled", 1'h1, driveActive);
        chk("led", 1'h1, runLed);
        $display("test pwrup done");
    endtask

    task automatic t_regs;
        logic [31:0] ex [6] = '{32'h0, 32'h0000_0F05, 32'h0032_0000,
            32'h0032_0000, 32'h641E_0000, 32'h0000_008B};
        for (int i = 0; i < 6; i++) begin
            bus(1'h0, 32'(i * 4), 32'h0);
            chk("reset", ex[i], rd);
        end
        chk("hresp", 1'h0, hresp);
        bus(1'h0, 32'h0000_0018, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'h1, 32'h0000_0008, 32'hFFFF_FFFF);
        bus(1'h0, 32'h0000_0008, 32'h0);
        chk("mask", 32'h03FF_03FF, rd);
        bus(1'h1, 32'h0000_0008, 32'h0032_0000);
        $display("test regs done");
    endtask

    task automatic t_phase;
        logic [2:0] g;
        for (int o = 0; o < 2; o++) begin
            bus(1'h1, 32'h0, 32'(o) << 2);
            repeat (4) begin
                cyc(1);
                g = phaseGate;
                cyc(1);
                chk("phase", o ? {g[1], g[2], g[0]} : g, phaseOut);
            end
        end
        $display("test phase done");
    endtask

    task automatic t_prog;
        bus(1'h1, 32'h0, 32'h2);
        @(posedge mclk);
        keypadProgMode <= 1'h1;
        progEntryReq <= 1'h1;
        cyc(2);
        chk("grant run", 1'h0, progEntryGrant);
        chk("disp run", 1'h0, progDisplayEn);
        bus(1'h1, 32'h0, 32'h12);
        run(1'h0);
        cyc(5);
        chk("coast", 1'h0, driveActive);
        chk("grant idle", 1'h1, progEntryGrant);
        bus(1'h1, 32'h0, 32'h10);
        run(1'h1);
        cyc(5);
        chk("sel0", 1'h0, driveActive);
        bus(1'h1, 32'h0, 32'h11);
        cyc(5);
        chk("sel1", 1'h1, driveActive);
        @(posedge mclk);
        keypadProgMode <= 1'h0;
        progEntryReq <= 1'h0;
        run(1'h0);
        cyc(5);
        bus(1'h1, 32'h0, 32'h0);
        $display("test prog done");
    endtask

    task automatic t_carrier;
        bus(1'h1, 32'h0000_000C, 32'h0033_0000);
        cyc(3);
        chk("carrier 51", 1'h1, carrierLow);
        bus(1'h1, 32'h0000_000C, 32'h0032_0000);
        cyc(3);
        chk("carrier 50", 1'h0, carrierLow);
        $display("test carrier done");
    endtask

    task automatic t_start;
        int n;
        bus(1'h1, 32'h0000_0008, 32'h0032_000A);
        run(1'h1);
        cyc(3);
        chk("start dc", 1'h1, brakeOut.dcInject);
        chk("start cur", 12'h032, brakeOut.current);
        for (n = 0; n < 300 && brakeOut.dcInject === 1'h1; n++) cyc(1);
        chk("start len", 1'h1, n > 94 && n < 106);
        bus(1'h1, 32'h0000_0008, 32'h0032_0000);
        $display("test start done");
    endtask

    // Power-up with acceptance set: run already high starts the drive
    task automatic t_accept;
        logic [11:0] c;
        @(posedge mclk);
        rst_b <= 1'h0;
        startupDone <= 1'h0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'h1;
        bus(1'h1, 32'h0, 32'h8);
        bus(1'h1, 32'h0000_0008, 32'h0032_000A);
        bus(1'h1, 32'h0000_0010, 32'h641E_012C);
        @(posedge mclk);
        startupDone <= 1'h1;
        cyc(4);
        chk("pwr run", 1'h1, driveActive);
        chk("no flash", 1'h1, runLed);
        chk("clamp", 12'h050, brakeOut.current);
        while (brakeOut.dcInject === 1'h1) begin
            c = brakeOut.current;
            cyc(1);
        end
        chk("ramp end", 12'h01E, c);
        bus(1'h1, 32'h0000_0008, 32'h0032_0000);
        $display("test accept done");
    endtask

    task automatic t_ref;
        @(posedge mclk);
        freqRefIn[2] <= 16'h1234;
        runCmdIn[1] <= 1'h1;
        bus(1'h1, 32'h0, 32'h0001_2800);
        cyc(3);
        chk("ref2", 32'h1234, freqRefOut);
        chk("run2", 1'h1, driveActive);
        $display("test ref done");
    endtask

    task automatic t_stop(input logic [2:0] m, e, input int len);
        logic [2:0] seen;
        int n;
        bus(1'h1, 32'h0, 32'(m) << 6);
        run(1'h1);
        for (n = 0; n < 400 && outputFreq < 16'h012C; n++) cyc(1);
        run(1'h0);
        for (n = 0; n < 400 && brakeOut[14:12] === 3'h0; n++) cyc(1);
        chk("brk freq", 1'h1, outputFreq <= 16'hF && outputFreq > 16'hB);
        seen = 3'h0;
        for (n = 0; n < 900 && driveActive === 1'h1; n++) begin
            seen |= brakeOut[14:12];
            cyc(1);
        end
        chk("brk kind", e, seen);
        chk("brk len", 1'h1, n > len - 20 && n < len + 20);
        $display("test stop mode %0d done", m);
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'h1;
        t_pwrup();
        t_regs();
        t_phase();
        t_prog();
        t_carrier();
        t_start();
        t_accept();
        t_stop(3'h0, 3'h4, 500);
        bus(1'h1, 32'h0000_000C, 32'h0032_0014);
        t_stop(3'h5, 3'h6, 700);
        t_stop(3'h3, 3'h1, 500);
        t_ref();
        results();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end
endmodule
